// file: shared/ovpseq_pkg.sv
/*
 * package for the overvoltage protect sequencer: register map, field
 * positions, reset values, timing figures and state encoding.
 * assumes a 50 MHz system clock and a 32-bit classic wishbone bus.
 */
`default_nettype none

package ovpseq_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned STARTUP_MS      = 50;   // typical startup delay
  localparam int unsigned BLANK_MS        = 50;   // indicator_blanking_time
  localparam int unsigned STARTUP_CYC     = (STARTUP_MS * (CLK_HZ / 1000));
  localparam int unsigned BLANK_CYC       = (BLANK_MS * (CLK_HZ / 1000));
  localparam int unsigned OVP_NS          = 100;  // gate pull-down on over supply
  localparam int unsigned DIS_NS          = 580;  // disable_response_time
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int unsigned OVP_CYC_RAW     = OVP_NS / CLK_NS;
  localparam int unsigned DIS_CYC_RAW     = DIS_NS / CLK_NS;
  localparam int unsigned OVP_CYC         = (OVP_CYC_RAW < 1) ? 1 : OVP_CYC_RAW;
  localparam int unsigned DIS_CYC         = (DIS_CYC_RAW < 1) ? 1 : DIS_CYC_RAW;
  localparam int unsigned CNT_W           = 24;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS         = 8'h00;
  localparam logic [7:0] STAT_OFS         = 8'h04;

  // ctrl fields
  localparam int unsigned CTRL_SW_OFF_BIT = 0;    // software forces gate off
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;

  // status fields
  localparam int unsigned STAT_STATE_LSB  = 0;    // four state bits
  localparam int unsigned STAT_GATE_BIT   = 4;
  localparam int unsigned STAT_FLAGN_BIT  = 5;
  localparam int unsigned STAT_UNDER_BIT  = 6;
  localparam int unsigned STAT_OVER_BIT   = 7;
  localparam int unsigned STAT_RUNN_BIT   = 8;

  // ****************************************************************
  // state encoding
  // ****************************************************************
  typedef enum logic [3:0] {
    OVPSEQ_OFF     = 4'h1,
    OVPSEQ_STARTUP = 4'h2,
    OVPSEQ_BLANK   = 4'h4,
    OVPSEQ_ON      = 4'h8
  } ovpseq_state_t;

endpackage : ovpseq_pkg

`default_nettype wire

// file: rtl/ovpseq_top.sv
/*
 * overvoltage protect sequencer: drives the charge-pump gate request and
 * the active-low fault indicator from the supply window comparators and
 * the active-low run allow pin; a wishbone slave exposes control/status.
 * assumes comparator and pin inputs already synchronous to clk_i.
 */
`default_nettype none

// Function
// RULE1 - valid supply and run allowed: wait startup delay before gate on
// RULE2 - after startup delay turn on charge pump and gate drive
// RULE3 - hold fault indicator low for blanking period after gate turns on
// RULE4 - after blanking, enter on state: gate on, indicator released
// RULE5 - supply valid and enabled: keep gate drive high
// RULE6 - normal operation keeps fault indicator released
// RULE7 - under supply in any state: indicator low, gate off immediately
// RULE8 - over supply: indicator low at once, gate forced off
// RULE9 - power-up with supply outside window: gate off, indicator low
// RULE10 - over supply during power-up: gate pull-down within 100 ns
// RULE11 - run allow low permits operation; high forces gate off
// RULE12 - run allow high turns gate off within 580 ns
// RULE13 - run allow low never overrides an under or over supply fault
// RULE14 - build option picks open-drain or push-pull fault indicator
// RULE15 - fault or disable during startup or blanking restarts whole sequence
module ovpseq_top
  import ovpseq_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = ovpseq_pkg::STARTUP_CYC,
  parameter int unsigned BLANK_CYCLES   = ovpseq_pkg::BLANK_CYC,
  parameter bit          OPEN_DRAIN     = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        under_supply_lockout_i,
  input  wire logic        over_supply_lockout_i,
  input  wire logic        run_allow_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             fet_gate_drive_o,
  output logic             fault_indicator_n_o,
  output logic             fault_indicator_n_oe_o
);
  import ovpseq_pkg::*;

  // ****************************************************************
  // state record
  // ****************************************************************
  typedef struct packed {
    ovpseq_state_t     state;
    logic [CNT_W-1:0]  cnt;
    logic              sw_off;
    logic              gate;
    logic              flag_n;
    logic              flag_oe;
    logic              ack;
    logic [31:0]       rdat;
  } ovpseq_regs_t;

  ovpseq_regs_t regs_r;
  ovpseq_regs_t regs_nxt;

  // decode of a word address against the map
  function automatic logic ovpseq_hit(input logic [7:0] adr, input logic [7:0] ofs);
    ovpseq_hit = (adr[7:2] == ofs[7:2]);
  endfunction : ovpseq_hit

  logic fault;
  logic allowed;
  logic req;

  // window check and enable combine
  assign fault   = under_supply_lockout_i | over_supply_lockout_i;
  assign allowed = ~run_allow_n_i & ~regs_r.sw_off;            // see RULE11
  assign req     = wb_cyc_i & wb_stb_i & ~regs_r.ack;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    regs_nxt     = regs_r;
    regs_nxt.ack = req;
    // register bus
    if (req && wb_we_i && ovpseq_hit(wb_adr_i, CTRL_OFS) && wb_sel_i[0]) begin
      regs_nxt.sw_off = wb_dat_i[CTRL_SW_OFF_BIT];
    end
    regs_nxt.rdat = 32'h0000_0000;
    if (req && !wb_we_i && ovpseq_hit(wb_adr_i, CTRL_OFS)) begin
      regs_nxt.rdat[CTRL_SW_OFF_BIT] = regs_r.sw_off;
    end else if (req && !wb_we_i && ovpseq_hit(wb_adr_i, STAT_OFS)) begin
      regs_nxt.rdat[STAT_STATE_LSB +: 4] = regs_r.state;
      regs_nxt.rdat[STAT_GATE_BIT]       = regs_r.gate;
      regs_nxt.rdat[STAT_FLAGN_BIT]      = regs_r.flag_n;
      regs_nxt.rdat[STAT_UNDER_BIT]      = under_supply_lockout_i;
      regs_nxt.rdat[STAT_OVER_BIT]       = over_supply_lockout_i;
      regs_nxt.rdat[STAT_RUNN_BIT]       = run_allow_n_i;
    end
    // sequencer
    case (regs_r.state)
      OVPSEQ_OFF: begin
        regs_nxt.cnt = '0;
        if (!fault && allowed) begin
          regs_nxt.state = OVPSEQ_STARTUP;                     // see RULE1
        end
      end
      OVPSEQ_STARTUP: begin
        regs_nxt.cnt = regs_r.cnt + 1'b1;
        if (regs_r.cnt >= CNT_W'(STARTUP_CYCLES - 2)) begin
          regs_nxt.state = OVPSEQ_BLANK;                       // see RULE2
          regs_nxt.cnt   = '0;
        end
      end
      OVPSEQ_BLANK: begin
        regs_nxt.cnt = regs_r.cnt + 1'b1;
        if (regs_r.cnt >= CNT_W'(BLANK_CYCLES - 1)) begin
          regs_nxt.state = OVPSEQ_ON;                          // see RULE4
          regs_nxt.cnt   = '0;
        end
      end
      OVPSEQ_ON: begin
        regs_nxt.cnt = '0;
      end
      default: begin
        regs_nxt.state = OVPSEQ_OFF;
        regs_nxt.cnt   = '0;
      end
    endcase
    // any fault or disable drops back to off
    if (fault || !allowed) begin                  // see RULE7, RULE8, RULE10, RULE12, RULE13
      regs_nxt.state = OVPSEQ_OFF;                             // see RULE15
      regs_nxt.cnt   = '0;
    end
    // outputs follow the next state, so faults act in one cycle
    regs_nxt.gate   = (regs_nxt.state == OVPSEQ_BLANK) ||
                      (regs_nxt.state == OVPSEQ_ON);           // see RULE5
    regs_nxt.flag_n = (regs_nxt.state == OVPSEQ_ON);           // see RULE3, RULE6
    // open drain drives only the low level
    regs_nxt.flag_oe = OPEN_DRAIN ? ~regs_nxt.flag_n : 1'b1;   // see RULE14
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_r.state   <= OVPSEQ_OFF;                            // see RULE9
      regs_r.cnt     <= '0;
      regs_r.sw_off  <= CTRL_RST[CTRL_SW_OFF_BIT];
      regs_r.gate    <= 1'b0;
      regs_r.flag_n  <= 1'b0;
      regs_r.flag_oe <= 1'b1;
      regs_r.ack     <= 1'b0;
      regs_r.rdat    <= 32'h0000_0000;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // output mapping
  assign fet_gate_drive_o       = regs_r.gate;
  assign fault_indicator_n_o    = regs_r.flag_n;
  assign fault_indicator_n_oe_o = regs_r.flag_oe;
  assign wb_ack_o               = regs_r.ack;
  assign wb_dat_o               = regs_r.rdat;

  // ****************************************************************
  // checks
  // ****************************************************************
  localparam int DLY_MAX = 2;

  sequence valid_s;
    !under_supply_lockout_i && !over_supply_lockout_i && !run_allow_n_i && !regs_r.sw_off;
  endsequence

  under_gate_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
    under_supply_lockout_i |=> !fet_gate_drive_o && !fault_indicator_n_o)
    else $error("gate or flag wrong after under supply");

  over_gate_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE8
    over_supply_lockout_i |=> !fet_gate_drive_o && !fault_indicator_n_o)
    else $error("gate or flag wrong after over supply");

  over_pulldown_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE10
    $rose(over_supply_lockout_i) |-> ##[1:DLY_MAX] !fet_gate_drive_o)
    else $error("gate pull-down too slow");

  disable_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE12
    $rose(run_allow_n_i) |-> ##[1:DLY_MAX] !fet_gate_drive_o)
    else $error("disable response too slow");

  run_no_override_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE13
    (!run_allow_n_i && (under_supply_lockout_i || over_supply_lockout_i))
      |=> !fet_gate_drive_o && !fault_indicator_n_o)
    else $error("enable overrode a supply fault");

  startup_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    (regs_r.state == OVPSEQ_OFF) ##1 (regs_r.state == OVPSEQ_STARTUP)
      |-> !fet_gate_drive_o)
    else $error("gate on during startup delay");

  gate_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    $rose(fet_gate_drive_o) |-> (regs_r.state == OVPSEQ_BLANK) && !fault_indicator_n_o)
    else $error("gate rose outside blanking entry");

  blank_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE3
    $rose(fet_gate_drive_o) |-> !fault_indicator_n_o [*8])
    else $error("indicator released early in blanking");

  on_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE4
    $rose(fault_indicator_n_o) |-> fet_gate_drive_o && $past(regs_r.state) == OVPSEQ_BLANK)
    else $error("on state entered wrongly");

  on_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE6
    (regs_r.state == OVPSEQ_ON) ##0 valid_s |=> fault_indicator_n_o && fet_gate_drive_o)
    else $error("indicator or gate lost in on state");

  restart_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE15
    (regs_r.state == OVPSEQ_BLANK) && run_allow_n_i |=> (regs_r.state == OVPSEQ_OFF))
    else $error("no restart after disable in blanking");

  od_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE14
    OPEN_DRAIN && fault_indicator_n_o |-> !fault_indicator_n_oe_o)
    else $error("open drain drove high level");

  // ****************************************************************
  // sequence building blocks
  // ****************************************************************
  // supply outside the valid window
  sequence fault_s;
    under_supply_lockout_i || over_supply_lockout_i;
  endsequence

  // pin or software asks for gate off
  sequence off_req_s;
    run_allow_n_i || regs_r.sw_off;
  endsequence

  // both outputs at their safe level
  sequence safe_out_s;
    !fet_gate_drive_o && !fault_indicator_n_o;
  endsequence

  // a bus request not yet answered
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  // ****************************************************************
  // sequencer checks, several built from the blocks
  // ****************************************************************
  // any supply fault lands in the safe state next cycle
  fault_safe_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
    fault_s |=> safe_out_s)
    else $error("supply fault left gate or flag wrong");

  // pin high or software off forces the safe state
  disable_safe_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE11
    off_req_s |=> safe_out_s)
    else $error("disable left gate or flag wrong");

  // gate only driven in blanking or on
  gate_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE5
    fet_gate_drive_o |-> (regs_r.state == OVPSEQ_BLANK) || (regs_r.state == OVPSEQ_ON))
    else $error("gate driven outside blanking or on");

  // released flag only in on state with gate up
  flag_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE6
    fault_indicator_n_o |-> (regs_r.state == OVPSEQ_ON) && fet_gate_drive_o)
    else $error("flag released outside on state");

  // reset parks the sequencer safely
  reset_safe_a: assert property (@(posedge clk_i) // see RULE9
    rst_i |=> safe_out_s ##0 ((regs_r.state == OVPSEQ_OFF) && fault_indicator_n_oe_o))
    else $error("reset did not park the sequencer");

  // gate only rises out of the startup delay
  gate_after_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    $rose(fet_gate_drive_o) |-> $past(regs_r.state) == OVPSEQ_STARTUP)
    else $error("gate rose without startup delay");

  // gate drop always comes with the flag asserted
  gate_drop_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
    $fell(fet_gate_drive_o) |-> !fault_indicator_n_o)
    else $error("gate dropped with flag released");

  // over supply held two cycles keeps outputs safe
  over_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE10
    over_supply_lockout_i ##1 over_supply_lockout_i |-> safe_out_s)
    else $error("over supply did not hold gate off");

  // fault during startup aborts the sequence
  restart_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE15
    (regs_r.state == OVPSEQ_STARTUP) ##0 fault_s |=> (regs_r.state == OVPSEQ_OFF))
    else $error("no restart after fault in startup");

  // valid conditions in off begin the startup delay
  off_to_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    (regs_r.state == OVPSEQ_OFF) ##0 valid_s
      |=> (regs_r.state == OVPSEQ_STARTUP) && !fet_gate_drive_o)
    else $error("startup delay not entered");

  // push-pull mode always drives the flag pin
  pp_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE14
    !OPEN_DRAIN || !fault_indicator_n_o |-> fault_indicator_n_oe_o)
    else $error("flag pin not driven when required");

  // ****************************************************************
  // register bus checks
  // ****************************************************************
  // every request is answered next cycle
  bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req_s |=> wb_ack_o)
    else $error("bus request not acknowledged");

  // ack lasts one cycle only
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // ack only after a request
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");

  // read data zero outside ack
  rdat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero while idle");

endmodule : ovpseq_top

`default_nettype wire

// file: test/ovpseq_far_model.sv
/* far side of the sequencer: host pull-up on the fault line and the fet.
   assumes the indicator enable is high only while the pin is driven. */
`default_nettype none
module ovpseq_far_model (
  input  wire logic flag_n_i,
  input  wire logic flag_oe_i,
  input  wire logic gate_i,
  output logic      host_flag_n_o,
  output logic      fet_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line floats up through the host pull-up
  assign host_flag_n_o = flag_oe_i ? flag_n_i : 1'b1;
  // fet conducts while the gate request is high
  assign fet_on_o = gate_i;
endmodule : ovpseq_far_model
`default_nettype wire

// file: test/test_ovpseq_top.sv
/* self-checking bench for the sequencer: supply faults, run pin, wishbone.
   assumes short counts of 10 cycles and an open-drain fault indicator. */
`default_nettype none
module test_ovpseq_top;
  import ovpseq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 10;
  localparam int unsigned BC = 10;
  logic        clk_i = 1'b0, rst_i = 1'b1, und = 1'b1, ovr = 1'b0, run_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, gate, flag_n, flag_oe, host_n, fet_on;
  int          bad_count = 0, n_checks = 0, n;
  ovpseq_top #(.STARTUP_CYCLES(SC), .BLANK_CYCLES(BC), .OPEN_DRAIN(1'b1)) u_ovpseq_top (
    .clk_i(clk_i), .rst_i(rst_i), .under_supply_lockout_i(und),
    .over_supply_lockout_i(ovr), .run_allow_n_i(run_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fet_gate_drive_o(gate),
    .fault_indicator_n_o(flag_n), .fault_indicator_n_oe_o(flag_oe));
  ovpseq_far_model u_ovpseq_far_model (.flag_n_i(flag_n), .flag_oe_i(flag_oe),
    .gate_i(gate), .host_flag_n_o(host_n), .fet_on_o(fet_on));
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  // classic single cycle, held until ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    check(k < 50, 1'b1, "no ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic set_in(input logic u, input logic o, input logic r);
    @(posedge clk_i);
    und <= u;
    ovr <= o;
    run_n <= r;
  endtask : set_in
  // count falling edges until gate (sel 0) or host flag (sel 1) reaches v
  task automatic wait_for(input bit s, input logic v);
    n = 0;
    while (((s ? host_n : gate) !== v) && n < 200) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_for
  // full power-up walk to the on state
  task automatic up();
    set_in(1'b0, 1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    check(n >= SC && n <= SC + 3, 1'b1, "startup length");
    check(host_n, 1'b0, "flag during blanking");
    wait_for(1'b1, 1'b1);
    check(n >= BC - 1 && n <= BC + 1, 1'b1, "blanking length");
    check({gate, fet_on}, 2'b11, "gate in on state");
  endtask : up
  // fault or disable: gate low within two cycles, then flag low at the next falling edge
  task automatic trip(input logic u, input logic o, input logic r);
    set_in(u, o, r);
    wait_for(1'b0, 1'b0);
    check(n <= 2, 1'b1, "gate off time");
    @(negedge clk_i);
    check(host_n, 1'b0, "flag on fault");
  endtask : trip
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100_000;
    bad_count++;
    tally_and_finish();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check({gate, host_n}, 2'b00, "power-up under supply");
    wb(1'b0, CTRL_OFS, 32'h0);
    check(q, CTRL_RST, "ctrl reset");
    wb(1'b0, STAT_OFS, 32'h0);
    check(q, 32'h0000_0041, "stat under off");
    wb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0, "unmapped read");
    repeat (3 * SC) @(posedge clk_i);
    check({gate, host_n}, 2'b00, "run low under fault");
    trip(1'b0, 1'b1, 1'b0);
    up();
    wb(1'b0, STAT_OFS, 32'h0);
    check(q, 32'h0000_0038, "stat on");
    trip(1'b0, 1'b1, 1'b0);
    up();
    trip(1'b1, 1'b0, 1'b0);
    set_in(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    trip(1'b1, 1'b0, 1'b0);
    up();
    trip(1'b0, 1'b0, 1'b1);
    set_in(1'b0, 1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    trip(1'b0, 1'b0, 1'b1);
    up();
    wb(1'b1, CTRL_OFS, 32'h0000_0001);
    wait_for(1'b0, 1'b0);
    check(n <= 2, 1'b1, "sw off gate");
    wb(1'b1, CTRL_OFS, 32'h0);
    wait_for(1'b0, 1'b1);
    check(n >= SC && n <= SC + 3, 1'b1, "restart after sw off");
    tally_and_finish();
  end
endmodule : test_ovpseq_top
`default_nettype wire
